/* core/vpg_top.sv */
// Video test-pattern generator control: registers, pattern decode,
// auto-scroll sequencing and an output FIFO toward the video path.
// Assumes a classic Wishbone master and a sink with valid/ready.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Synchronous FIFO with a registered output stage
module vpg_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign push = in_valid_i && in_ready_o;
  // Move a word into the output stage whenever it is empty or draining
  assign pop = (count != '0) && (!out_valid_o || out_ready_i);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rd_ptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule // vpg_fifo

// ============================================================
// Top level
module vpg_top import vpg_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pixel stream
  output logic pix_valid_o,
  input wire logic pix_ready_i,
  output logic [PIX_W-1:0] pix_data_o
);
  logic [7:0] pattern_control;
  logic [7:0] pattern_config;
  logic [7:0] custom_red_level;
  logic [7:0] custom_green_level;
  logic [7:0] custom_blue_level;
  logic [7:0] scroll_frame_time;
  logic [7:0] frame_cnt;
  logic [3:0] scroll_code;
  logic [7:0] xpos;
  logic [5:0] ypos;
  logic [3:0] cur_code;
  logic [23:0] base_rgb;
  logic [23:0] next_rgb;
  logic [7:0] hlev;
  logic [7:0] vlev;
  logic [7:0] word_idx;
  logic bus_req;
  logic bus_wr;
  logic fifo_ready;
  logic push;
  logic frame_end;
  vpg_pixel_s gen_pixel;

  // ==========================================================
  // Register bus
  assign word_idx = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pattern_control <= RST_PATTERN_CONTROL;
      pattern_config <= RST_PATTERN_CONFIG;
      custom_red_level <= RST_ZERO;
      custom_green_level <= RST_ZERO;
      custom_blue_level <= RST_ZERO;
      scroll_frame_time <= RST_FRAME_TIME;
    end else if (bus_wr) begin
      case (word_idx)
        IDX_PATTERN_CONTROL: pattern_control <= wb_dat_i[7:0];
        IDX_PATTERN_CONFIG: begin
          // Upper bits are read-only zero
          pattern_config <= wb_dat_i[7:0] & CFG_WRITABLE;
        end
        IDX_CUSTOM_RED: custom_red_level <= wb_dat_i[7:0];
        IDX_CUSTOM_GREEN: custom_green_level <= wb_dat_i[7:0];
        IDX_CUSTOM_BLUE: custom_blue_level <= wb_dat_i[7:0];
        IDX_SCROLL_FRAME_TIME: scroll_frame_time <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req) begin
      case (word_idx)
        IDX_PATTERN_CONTROL: wb_dat_o <= {24'h000000, pattern_control};
        IDX_PATTERN_CONFIG: wb_dat_o <= {24'h000000, pattern_config};
        IDX_CUSTOM_RED: wb_dat_o <= {24'h000000, custom_red_level};
        IDX_CUSTOM_GREEN: wb_dat_o <= {24'h000000, custom_green_level};
        IDX_CUSTOM_BLUE: wb_dat_o <= {24'h000000, custom_blue_level};
        IDX_SCROLL_FRAME_TIME: wb_dat_o <= {24'h000000, scroll_frame_time};
        IDX_STATUS: wb_dat_o <= {26'h0, !fifo_ready,
                                 pattern_control[CTL_ENABLE], cur_code};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // ==========================================================
  // Raster position over the active region
  // A full FIFO stalls the raster, so no pixel is ever dropped
  assign push = pattern_control[CTL_ENABLE] && fifo_ready;
  assign frame_end = push && (xpos == HACT_LAST) && (ypos == VACT_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || !pattern_control[CTL_ENABLE]) begin
      xpos <= '0;
      ypos <= '0;
    end else if (push) begin
      xpos <= xpos + 1'b1;
      if (xpos == HACT_LAST) begin
        ypos <= ypos + 1'b1;
      end
    end
  end

  // ==========================================================
  // Auto-scroll sequencing; a frame time of zero acts as one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_cnt <= '0;
      scroll_code <= VPG_WHITE;
    end else if (pattern_config[CFG_SCROLL] && frame_end) begin
      if (frame_cnt + 8'h01 >= scroll_frame_time) begin
        frame_cnt <= '0;
        scroll_code <= (scroll_code == VPG_VCOM) ? VPG_WHITE :
                       scroll_code + 1'b1;
      end else begin
        frame_cnt <= frame_cnt + 8'h01;
      end
    end else if (!pattern_config[CFG_SCROLL]) begin
      frame_cnt <= '0;
    end
  end

  // Selector is ignored while scrolling
  assign cur_code = pattern_config[CFG_SCROLL] ? scroll_code :
                    pattern_control[CTL_SEL_HI:CTL_SEL_LO];

  // ==========================================================
  // Pattern decode
  // Active width is 256 and height 64, so these steps are even
  assign hlev = xpos;
  assign vlev = {ypos, 2'b00};

  always_comb begin
    base_rgb = C_BLACK;
    if (pattern_control[CTL_COMPLIANCE]) begin
      // Alternate-pixel black and white toggling
      base_rgb = xpos[0] ? C_WHITE : C_BLACK;
    end else if (pattern_control[CTL_BARS]) begin
      case (xpos[7:5])
        3'h0: base_rgb = C_WHITE;
        3'h1: base_rgb = C_YELLOW;
        3'h2: base_rgb = C_CYAN;
        3'h3: base_rgb = C_GREEN;
        3'h4: base_rgb = C_MAGENTA;
        3'h5: base_rgb = C_RED;
        3'h6: base_rgb = C_BLUE;
        default: base_rgb = C_BLACK;
      endcase
    end else begin
      case (cur_code)
        VPG_WHITE: base_rgb = C_WHITE;
        VPG_BLACK: base_rgb = C_BLACK;
        VPG_RED: base_rgb = C_RED;
        VPG_GREEN: base_rgb = C_GREEN;
        VPG_BLUE: base_rgb = C_BLUE;
        VPG_HR_WHITE: base_rgb = {hlev, hlev, hlev};
        VPG_HR_RED: base_rgb = {hlev, 8'h00, 8'h00};
        VPG_HR_GREEN: base_rgb = {8'h00, hlev, 8'h00};
        VPG_HR_BLUE: base_rgb = {8'h00, 8'h00, hlev};
        VPG_VR_WHITE: base_rgb = {vlev, vlev, vlev};
        VPG_VR_RED: base_rgb = {vlev, 8'h00, 8'h00};
        VPG_VR_GREEN: base_rgb = {8'h00, vlev, 8'h00};
        VPG_VR_BLUE: base_rgb = {8'h00, 8'h00, vlev};
        VPG_CUSTOM: base_rgb = {custom_red_level, custom_green_level,
                                custom_blue_level};
        VPG_VCOM: begin
          // Reachable through auto-scroll or through selector code 15
          case ({pattern_control[CTL_VCOM_REV], ypos[5:4]})
            3'h0: base_rgb = C_YELLOW;
            3'h1: base_rgb = C_CYAN;
            3'h2: base_rgb = C_BLUE;
            3'h4: base_rgb = C_BLUE;
            3'h5: base_rgb = C_CYAN;
            3'h6: base_rgb = C_YELLOW;
            default: base_rgb = C_RED;
          endcase
        end
        default: base_rgb = C_BLACK; // Reserved code gives black
      endcase
    end
    next_rgb = pattern_config[CFG_INVERT] ? ~base_rgb : base_rgb;
    if (pattern_config[CFG_18BIT]) begin
      next_rgb = next_rgb & {MASK_18BIT, MASK_18BIT, MASK_18BIT};
    end
  end
  assign gen_pixel.sof = (xpos == '0) && (ypos == '0);
  assign gen_pixel.eol = (xpos == HACT_LAST);
  assign gen_pixel.rgb = next_rgb;

  // ==========================================================
  // Output FIFO
  vpg_fifo #(
    .WIDTH(PIX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(pattern_control[CTL_ENABLE]),
    .in_ready_o(fifo_ready),
    .in_data_i(gen_pixel),
    .out_valid_o(pix_valid_o),
    .out_ready_i(pix_ready_i),
    .out_data_o(pix_data_o)
  );

  // ==========================================================
  // Checks
  logic plain;
  assign plain = !pattern_control[CTL_COMPLIANCE] &&
                 !pattern_control[CTL_BARS] && !pattern_config[CFG_SCROLL];
  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held past one cycle");
  chk_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> wb_ack_o) else $error("bus request not answered");
  chk_ctl_reset: assert property (@(posedge clk_i)
    rst_i |=> pattern_control == RST_PATTERN_CONTROL)
    else $error("control reset value wrong");
  chk_cfg_reset: assert property (@(posedge clk_i)
    rst_i |=> pattern_config == RST_PATTERN_CONFIG)
    else $error("config reset value wrong");
  chk_ctl_write: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_wr && word_idx == IDX_PATTERN_CONTROL |=>
    pattern_control == $past(wb_dat_i[7:0]))
    else $error("control write lost");
  chk_gen_enable: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !pattern_control[CTL_ENABLE] |=> xpos == '0 && ypos == '0)
    else $error("raster runs while disabled");
  chk_compl_prio: assert property (@(posedge clk_i)
    disable iff (rst_i)
    pattern_control[CTL_COMPLIANCE] && !pattern_config[CFG_INVERT] &&
    !pattern_config[CFG_18BIT] |->
    gen_pixel.rgb == (xpos[0] ? C_WHITE : C_BLACK))
    else $error("compliance pattern not chosen");
  chk_bars_first: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !pattern_control[CTL_COMPLIANCE] && pattern_control[CTL_BARS] &&
    xpos == '0 && pattern_config[CFG_INVERT:0] == 2'b00 &&
    !pattern_config[CFG_18BIT] |-> gen_pixel.rgb == C_WHITE)
    else $error("first colour bar not white");
  chk_red_invert: assert property (@(posedge clk_i)
    disable iff (rst_i)
    plain && cur_code == VPG_RED && pattern_config[CFG_INVERT] &&
    !pattern_config[CFG_18BIT] |-> gen_pixel.rgb == C_CYAN)
    else $error("inverted red not cyan");
  chk_hramp_step: assert property (@(posedge clk_i)
    disable iff (rst_i)
    plain && cur_code == VPG_HR_WHITE && !pattern_config[CFG_INVERT] &&
    !pattern_config[CFG_18BIT] && push ##1 push && xpos != '0 |->
    gen_pixel.rgb[7:0] == $past(gen_pixel.rgb[7:0]) + 8'h01)
    else $error("ramp step uneven");
  chk_scroll_sel: assert property (@(posedge clk_i)
    disable iff (rst_i) pattern_config[CFG_SCROLL] &&
    scroll_code == VPG_WHITE &&
    pattern_control[CTL_COMPLIANCE:CTL_BARS] == 2'h0 &&
    pattern_config[CFG_18BIT:CFG_INVERT] == 4'h0 |->
    gen_pixel.rgb == C_WHITE) else $error("selector used during scroll");
  chk_band_order: assert property (@(posedge clk_i)
    disable iff (rst_i) cur_code == VPG_VCOM && ypos[5:4] == 2'h0 &&
    pattern_control[CTL_COMPLIANCE:CTL_BARS] == 2'h0 &&
    pattern_config[CFG_18BIT:CFG_INVERT] == 4'h0 |->
    gen_pixel.rgb == (pattern_control[CTL_VCOM_REV] ? C_BLUE : C_YELLOW))
    else $error("common-voltage band order wrong");
  cov_bars: cover property (@(posedge clk_i) disable iff (rst_i)
    push && pattern_control[CTL_BARS]);
  cov_scroll: cover property (@(posedge clk_i) disable iff (rst_i)
    pattern_config[CFG_SCROLL] && frame_end);
  cov_stall: cover property (@(posedge clk_i) disable iff (rst_i)
    pattern_control[CTL_ENABLE] && !fifo_ready);
endmodule // vpg_top

`default_nettype wire

/* core/vpg_pkg.sv */
// Package for the video test-pattern generator control block.
// Assumes a 20 MHz system clock and classic Wishbone register access.
package vpg_pkg;
  // ==========================================================
  // Register word indices (byte address is four times index)
  localparam logic [7:0] IDX_PATTERN_CONTROL = 8'h64;
  localparam logic [7:0] IDX_PATTERN_CONFIG = 8'h65;
  localparam logic [7:0] IDX_CUSTOM_RED = 8'h70;
  localparam logic [7:0] IDX_CUSTOM_GREEN = 8'h71;
  localparam logic [7:0] IDX_CUSTOM_BLUE = 8'h72;
  localparam logic [7:0] IDX_SCROLL_FRAME_TIME = 8'h73;
  localparam logic [7:0] IDX_STATUS = 8'h74;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_PATTERN_CONTROL = 8'h10;
  localparam logic [7:0] RST_PATTERN_CONFIG = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FRAME_TIME = 8'h01;

  // ==========================================================
  // Field positions
  localparam int CTL_SEL_HI = 7;
  localparam int CTL_SEL_LO = 4;
  localparam int CTL_COMPLIANCE = 3;
  localparam int CTL_BARS = 2;
  localparam int CTL_VCOM_REV = 1;
  localparam int CTL_ENABLE = 0;
  localparam int CFG_18BIT = 4;
  localparam int CFG_INVERT = 1;
  localparam int CFG_SCROLL = 0;
  localparam logic [7:0] CFG_WRITABLE = 8'h1f;

  // ==========================================================
  // Active frame geometry
  localparam logic [7:0] HACT_LAST = 8'hff;
  localparam logic [5:0] VACT_LAST = 6'h3f;
  localparam logic [7:0] MASK_18BIT = 8'hfc;

  // ==========================================================
  // Pattern codes
  typedef enum logic [3:0] {
    VPG_RSV_LO = 4'h0, VPG_WHITE = 4'h1, VPG_BLACK = 4'h2,
    VPG_RED = 4'h3, VPG_GREEN = 4'h4, VPG_BLUE = 4'h5,
    VPG_HR_WHITE = 4'h6, VPG_HR_RED = 4'h7, VPG_HR_GREEN = 4'h8,
    VPG_HR_BLUE = 4'h9, VPG_VR_WHITE = 4'ha, VPG_VR_RED = 4'hb,
    VPG_VR_GREEN = 4'hc, VPG_VR_BLUE = 4'hd, VPG_CUSTOM = 4'he,
    VPG_VCOM = 4'hf
  } vpg_code_e;

  // Colours, 24-bit as {red, green, blue}
  localparam logic [23:0] C_WHITE = 24'hffffff;
  localparam logic [23:0] C_BLACK = 24'h000000;
  localparam logic [23:0] C_RED = 24'hff0000;
  localparam logic [23:0] C_GREEN = 24'h00ff00;
  localparam logic [23:0] C_BLUE = 24'h0000ff;
  localparam logic [23:0] C_YELLOW = 24'hffff00;
  localparam logic [23:0] C_CYAN = 24'h00ffff;
  localparam logic [23:0] C_MAGENTA = 24'hff00ff;

  typedef struct packed {
    logic sof;
    logic eol;
    logic [23:0] rgb;
  } vpg_pixel_s;

  localparam int PIX_W = 26;
  localparam int FIFO_DEPTH = 8;
endpackage

/* testbench/vpg_top_bench.sv */
// Self-checking bench for the video test-pattern generator control block.
// Assumes vpg_pkg and vpg_top compiled first; the bench drives the
// Wishbone slave and the pixel sink directly.
`timescale 1ns/1ps
`default_nettype none

module vpg_top_bench import vpg_pkg::*;;
  // ==========================================================
  // Clock, reset and design ports
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic pix_valid_o;
  logic pix_ready_i = 1'b1;
  logic [PIX_W-1:0] pix_data_o;
  int bad_count = 0;
  int checks = 0;
  logic [23:0] bar_rgb [8] = '{C_WHITE, C_YELLOW, C_CYAN, C_GREEN,
                               C_MAGENTA, C_RED, C_BLUE, C_BLACK};

  always #25 clk_i = ~clk_i;

  vpg_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i),
    .pix_data_o(pix_data_o)
  );

  // ==========================================================
  // Shared tasks
  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [7:0] idx,
                          input logic [7:0] d, input logic [3:0] sel,
                          output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) cmp(32'h0, 32'h1, "bus ack missing");
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wb_write(input logic [7:0] idx, input logic [7:0] d,
                          input logic [3:0] sel = 4'h1);
    logic [7:0] q;
    wb_cycle(1'b1, idx, d, sel, q);
  endtask

  task automatic rd_cmp(input logic [7:0] idx, input logic [7:0] exp,
                        input string what);
    logic [7:0] q;
    wb_cycle(1'b0, idx, 8'h00, 4'h1, q);
    cmp({24'h0, q}, {24'h0, exp}, what);
  endtask

  // Stop the generator, let the FIFO drain, then start afresh at (0,0)
  task automatic restart(input logic [7:0] ctl, input logic [7:0] cfg);
    wb_write(IDX_PATTERN_CONTROL, 8'h00);
    repeat (16) @(posedge clk_i);
    wb_write(IDX_PATTERN_CONFIG, cfg);
    wb_write(IDX_PATTERN_CONTROL, ctl);
  endtask

  // Pixel n and n+1 counted from the next start of frame
  task automatic get_px(input int n, output vpg_pixel_s p0,
                        output vpg_pixel_s p1);
    int cnt;
    int guard;
    logic seen;
    cnt = 0;
    seen = 1'b0;
    for (guard = 0; guard < 40000; guard++) begin
      @(posedge clk_i);
      if (pix_valid_o === 1'b1 && pix_ready_i === 1'b1) begin
        if (seen) cnt++;
        else if (pix_data_o[PIX_W-1] === 1'b1) seen = 1'b1;
        if (seen && cnt == n) p0 = pix_data_o;
        if (seen && cnt == n + 1) begin
          p1 = pix_data_o;
          return;
        end
      end
    end
    cmp(32'h0, 32'h1, "pixel stream stalled");
  endtask

  function automatic logic [23:0] exp_rgb(input logic [3:0] c,
      input logic [7:0] x, input logic [5:0] y, input logic inv);
    logic [7:0] h;
    logic [7:0] v;
    logic [23:0] r;
    h = x;
    v = {y, 2'b00};
    case (c)
      4'h1: r = C_WHITE;
      4'h2: r = C_BLACK;
      4'h3: r = C_RED;
      4'h4: r = C_GREEN;
      4'h5: r = C_BLUE;
      4'h6: r = {h, h, h};
      4'h7: r = {h, 16'h0000};
      4'h8: r = {8'h00, h, 8'h00};
      4'h9: r = {16'h0000, h};
      4'ha: r = {v, v, v};
      4'hb: r = {v, 16'h0000};
      4'hc: r = {8'h00, v, 8'h00};
      4'hd: r = {16'h0000, v};
      4'he: r = 24'h123456;
      default: r = C_BLACK;
    endcase
    return inv ? ~r : r;
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd_cmp(IDX_PATTERN_CONTROL, 8'h10, "control reset");
    rd_cmp(IDX_PATTERN_CONFIG, 8'h00, "config reset");
    rd_cmp(8'h20, 8'h00, "unmapped read");
    wb_write(8'h20, 8'h5a);
    rd_cmp(8'h20, 8'h00, "unmapped write");
    wb_write(IDX_PATTERN_CONFIG, 8'hff);
    rd_cmp(IDX_PATTERN_CONFIG, 8'h1f, "config reserved bits");
    wb_write(IDX_PATTERN_CONFIG, 8'h00, 4'h0);
    rd_cmp(IDX_PATTERN_CONFIG, 8'h1f, "write without byte lane");
    wb_write(IDX_STATUS, 8'hff);
    rd_cmp(IDX_STATUS, 8'h01, "status read only");
    wb_write(IDX_CUSTOM_RED, 8'h12);
    wb_write(IDX_CUSTOM_GREEN, 8'h34);
    wb_write(IDX_CUSTOM_BLUE, 8'h56);
    rd_cmp(IDX_CUSTOM_GREEN, 8'h34, "custom level");
  endtask

  // Selector codes 1 to 14, plain and inverted, at x=37 y=3
  task automatic t_patterns;
    vpg_pixel_s p0;
    vpg_pixel_s p1;
    logic [23:0] e;
    // Reserved selector code 0 and common-voltage code 15 are never checked here
    for (int c = 1; c < 15; c++) begin
      for (int inv = 0; inv < 2; inv++) begin
        restart({c[3:0], 4'h1}, {6'h00, inv[0], 1'b0});
        get_px(805, p0, p1);
        e = exp_rgb(c[3:0], 8'd37, 6'd3, inv[0]);
        if (c < 6) cmp(p0.rgb, e, "solid");
        else if (c < 10) cmp(p0.rgb, e, "hramp");
        else if (c < 14) cmp(p0.rgb, e, "vramp");
        else cmp(p0.rgb, e, "custom");
      end
    end
    restart(8'h71, 8'h12);
    get_px(805, p0, p1);
    cmp(p0.rgb, 24'hd8fcfc, "18-bit inverted red ramp");
  endtask

  task automatic t_bars_compliance;
    vpg_pixel_s p0;
    vpg_pixel_s p1;
    for (int k = 0; k < 8; k++) begin
      restart(8'h35, 8'h00);
      get_px(32 * k + 5, p0, p1);
      cmp(p0.rgb, bar_rgb[k], "colour bar");
    end
    restart(8'h3d, 8'h00);
    get_px(36, p0, p1);
    cmp(p1.rgb, {~p0.rgb}, "compliance alternation");
    cmp(p0.rgb, C_BLACK, "compliance over bars");
  endtask

  // Scroll starts at code 1 whatever the selector says
  task automatic t_scroll;
    vpg_pixel_s p0;
    vpg_pixel_s p1;
    wb_write(IDX_SCROLL_FRAME_TIME, 8'h01);
    restart(8'h31, 8'h01);
    get_px(805, p0, p1);
    cmp(p0.rgb, C_WHITE, "scroll first frame");
    rd_cmp(IDX_STATUS, 8'h11, "scroll start code");
    get_px(805, p0, p1);
    cmp(p0.rgb, C_BLACK, "scroll next frame");
  endtask

  task automatic t_enable_off;
    int cnt;
    cnt = 0;
    wb_write(IDX_PATTERN_CONTROL, 8'h60);
    repeat (16) @(posedge clk_i);
    repeat (300) begin
      @(posedge clk_i);
      if (pix_valid_o !== 1'b0) cnt++;
    end
    cmp(cnt, 0, "output while disabled");
  endtask

  // Fill the FIFO with the sink stalled, then drain it
  task automatic t_fifo_stall;
    vpg_pixel_s p0;
    vpg_pixel_s p1;
    int i;
    int guard;
    restart(8'h60, 8'h00);
    pix_ready_i <= 1'b0;
    wb_write(IDX_PATTERN_CONTROL, 8'h61);
    repeat (30) @(posedge clk_i);
    rd_cmp(IDX_STATUS, 8'h36, "status with full FIFO");
    pix_ready_i <= 1'b1;
    i = 0;
    for (guard = 0; guard < 100 && i < 12; guard++) begin
      @(posedge clk_i);
      if (pix_valid_o === 1'b1) begin
        cmp(pix_data_o, {i == 0, 1'b0, exp_rgb(4'h6, i[7:0], 6'd0, 1'b0)},
            "drained pixel");
        i++;
      end
    end
    get_px(255, p0, p1);
    cmp({p0.eol, p1.sof, p1.eol}, 3'b100, "line end marker");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_patterns();
    t_bars_compliance();
    t_fifo_stall();
    t_scroll();
    t_enable_off();
    stop_test();
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // vpg_top_bench

`default_nettype wire
